// file: hw/cold_load_inrush_detector.sv
/*
 Cold-load pickup and magnetizing inrush detector, one clock domain.
 Assumes magnitudes and ratios come from logic on clk, with a cycle_done
 strobe from the measurement chain once a full cycle has been analysed.
*/
`timescale 1ns/1ps
`include "cold_load_defs.svh"
module cold_load_inrush_detector #(
	parameter int RISE_WINDOW_CYC = `RISE_WINDOW_CYC,
	parameter int STEP_CYC = `STEP_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input cold_load_pkg::phase_mag_t phase_mag,
	input cold_load_pkg::phase_ratio_t second_harmonic_ratio,
	input wire logic cycle_done,
	input wire logic [15:0] idle_current_threshold,
	input wire logic [15:0] start_threshold,
	input wire logic [15:0] pickup_threshold,
	input wire logic [15:0] max_time,
	input wire logic [7:0] harmonic_threshold,
	output logic cold_load,
	output logic inrush,
	output logic inrush_block
);
	cold_load_pkg::det_regs_t r_r;
	cold_load_pkg::det_regs_t r_nxt;

	// Settings other than pickup_threshold are pulled to the nearest limit of their range, never refused
	function automatic logic [15:0] clamp16(
		input logic [15:0] v,
		input logic [15:0] lo,
		input logic [15:0] hi
	);
		if (v < lo) begin
			clamp16 = lo;
		end else if (v > hi) begin
			clamp16 = hi;
		end else begin
			clamp16 = v;
		end
	endfunction : clamp16

	// Ratio threshold has only an upper limit
	function automatic logic [7:0] cap8(
		input logic [7:0] v,
		input logic [7:0] hi
	);
		if (v > hi) begin
			cap8 = hi;
		end else begin
			cap8 = v;
		end
	endfunction : cap8

	// Phase picker shared by the per-phase comparators
	function automatic logic [15:0] mag_at(
		input cold_load_pkg::phase_mag_t m,
		input int idx
	);
		case (idx)
			0: mag_at = m.l1;
			1: mag_at = m.l2;
			2: mag_at = m.l3;
			default: mag_at = 16'h0000;
		endcase
	endfunction : mag_at

	function automatic logic [7:0] ratio_at(
		input cold_load_pkg::phase_ratio_t r,
		input int idx
	);
		case (idx)
			0: ratio_at = r.r1;
			1: ratio_at = r.r2;
			2: ratio_at = r.r3;
			default: ratio_at = 8'h00;
		endcase
	endfunction : ratio_at

	logic [15:0] idle_eff;
	logic [15:0] start_eff;
	logic [15:0] maxt_eff;
	logic [7:0] harm_eff;
	logic [2:0] below_idle;
	logic [2:0] above_start;
	logic [2:0] below_pickup;
	logic [2:0] over_harm;
	logic all_idle;
	logic any_start;
	logic any_pickup;
	logic harm_hit;
	logic win_expired;
	logic step_tick;
	logic hold_done;
	logic ratio_due;

	always_comb begin
		idle_eff = clamp16(idle_current_threshold, `IDLE_MIN, `IDLE_MAX);
		start_eff = clamp16(start_threshold, `START_MIN, `START_MAX);
		maxt_eff = clamp16(max_time, `MAXT_MIN, `MAXT_MAX);
		harm_eff = cap8(harmonic_threshold, `HARM_MAX);
	end

	// Same comparators on every phase, every clock
	for (genvar ph = 0; ph < 3; ph++) begin : g_phase
		logic [15:0] mag_ph;
		logic [7:0] ratio_ph;
		assign mag_ph = mag_at(phase_mag, ph);
		assign ratio_ph = ratio_at(second_harmonic_ratio, ph);
		assign below_idle[ph] = mag_ph < idle_eff;
		assign above_start[ph] = mag_ph > start_eff;
		assign below_pickup[ph] = mag_ph < pickup_threshold;
		assign over_harm[ph] = ratio_ph > harm_eff;
	end

	always_comb begin
		all_idle = &below_idle;
		any_start = |above_start;
		// One phase at pickup level keeps cold load on
		any_pickup = !(&below_pickup);
		harm_hit = |over_harm;
		win_expired = r_r.win_cnt >= 32'(RISE_WINDOW_CYC);
		step_tick = r_r.step_cnt >= 32'(STEP_CYC);
		hold_done = r_r.hold_cnt >= maxt_eff;
		// Ratio judged once; later cycles cannot reopen blocking
		ratio_due = cycle_done && !r_r.ratio_seen;
	end

	always_comb begin
		r_nxt = r_r;
		case (r_r.state)
			cold_load_pkg::ST_WAIT_IDLE: begin
				if (all_idle) begin
					r_nxt.state = cold_load_pkg::ST_ARMED;
				end
			end
			cold_load_pkg::ST_ARMED: begin
				// Window restarts on every arming
				r_nxt.win_cnt = '0;
				if (!all_idle) begin
					r_nxt.state = cold_load_pkg::ST_RISING;
				end
			end
			cold_load_pkg::ST_RISING: begin
				r_nxt.win_cnt = r_r.win_cnt + 32'h00000001;
				if (all_idle) begin
					r_nxt.state = cold_load_pkg::ST_ARMED;
				end else if (any_start) begin
					r_nxt.state = cold_load_pkg::ST_ACTIVE;
					r_nxt.cold_load = 1'b1;
					r_nxt.inrush_block = 1'b1;
					r_nxt.inrush = (harm_eff == 8'h00);
					r_nxt.ratio_seen = 1'b0;
					r_nxt.hold_cnt = '0;
					r_nxt.step_cnt = '0;
				end else if (win_expired) begin
					// Slow rise needs a fresh idle spell before arming again
					r_nxt.state = cold_load_pkg::ST_WAIT_IDLE;
				end
			end
			cold_load_pkg::ST_ACTIVE: begin
				// Step tick keeps the hold counter narrow
				if (step_tick) begin
					r_nxt.step_cnt = '0;
					r_nxt.hold_cnt = r_r.hold_cnt + 16'h0001;
				end else begin
					r_nxt.step_cnt = r_r.step_cnt + 32'h00000001;
				end
				if (ratio_due) begin
					r_nxt.ratio_seen = 1'b1;
					if (harm_hit || harm_eff == 8'h00) begin
						r_nxt.inrush = 1'b1;
						r_nxt.inrush_block = 1'b1;
					end else begin
						r_nxt.inrush_block = 1'b0;
					end
				end
				// Either ending returns to idle search so a fresh energisation re-arms
				if (hold_done || !any_pickup) begin
					r_nxt.state = cold_load_pkg::ST_WAIT_IDLE;
					r_nxt.cold_load = 1'b0;
					r_nxt.inrush = 1'b0;
					r_nxt.inrush_block = 1'b0;
				end
			end
			default: begin
				r_nxt.state = cold_load_pkg::ST_WAIT_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			// Synchronous clear of every state field
			r_r <= '{state: cold_load_pkg::ST_WAIT_IDLE, default: '0};
		end else begin
			r_r <= r_nxt;
		end
	end

	assign cold_load = r_r.cold_load;
	assign inrush = r_r.inrush;
	assign inrush_block = r_r.inrush_block;
endmodule : cold_load_inrush_detector

// file: pkg/cold_load_defs.svh
/*
 Timing counts and setting limits of the cold-load / inrush detector.
 Assumes a 20 MHz clock and currents scaled in hundredths of nominal.
*/
`ifndef COLD_LOAD_DEFS_SVH
`define COLD_LOAD_DEFS_SVH
`define CLK_HZ 20000000
`define RISE_WINDOW_MS 80
`define RISE_WINDOW_CYC ((`RISE_WINDOW_MS * (`CLK_HZ / 1000)) - 1)
`define STEP_MS 10
`define STEP_CYC ((`STEP_MS * (`CLK_HZ / 1000)) - 1)
`define IDLE_MIN 16'h0001
`define IDLE_MAX 16'h0032
`define START_MIN 16'h001E
`define START_MAX 16'h03E8
`define MAXT_MIN 16'h0001
`define MAXT_MAX 16'h7530
`define HARM_MAX 8'h63
`endif

// file: pkg/cold_load_pkg.sv
/*
 Types of the cold-load / inrush detector.
 Assumes magnitudes arrive as 16-bit values in hundredths of nominal current.
*/
package cold_load_pkg;
	typedef enum logic [1:0] {ST_WAIT_IDLE, ST_ARMED, ST_RISING, ST_ACTIVE} det_state_t;
	typedef struct packed {
		logic [15:0] l1;
		logic [15:0] l2;
		logic [15:0] l3;
	} phase_mag_t;
	typedef struct packed {
		logic [7:0] r1;
		logic [7:0] r2;
		logic [7:0] r3;
	} phase_ratio_t;
	typedef struct packed {
		det_state_t state;
		logic [31:0] win_cnt;
		logic [31:0] step_cnt;
		logic [15:0] hold_cnt;
		logic cold_load;
		logic inrush;
		logic inrush_block;
		logic ratio_seen;
	} det_regs_t;
endpackage : cold_load_pkg

// file: testbench/cold_load_chk.sv
/* Checker bound to the detector top.
 Assumes one clock, synchronous active-low reset. */
`timescale 1ns/1ps
module cold_load_chk #(parameter int STEP_CYC = 4) (
	input wire logic clk,
	input wire logic resetn,
	input cold_load_pkg::phase_mag_t phase_mag,
	input cold_load_pkg::phase_ratio_t second_harmonic_ratio,
	input wire logic cycle_done,
	input wire logic [15:0] start_threshold,
	input wire logic [15:0] pickup_threshold,
	input wire logic [15:0] max_time,
	input wire logic [7:0] harmonic_threshold,
	input wire logic cold_load,
	input wire logic inrush,
	input wire logic inrush_block
);
	cold_load_pkg::phase_mag_t m;
	cold_load_pkg::phase_ratio_t r;
	logic hi, lo, hm, first;
	logic [31:0] on_r;
	assign m = phase_mag;
	assign r = second_harmonic_ratio;
	assign hi = m.l1 > start_threshold || m.l2 > start_threshold || m.l3 > start_threshold;
	assign lo = m.l1 < pickup_threshold && m.l2 < pickup_threshold && m.l3 < pickup_threshold;
	assign hm = r.r1 > harmonic_threshold || r.r2 > harmonic_threshold || r.r3 > harmonic_threshold;
	assign first = cold_load && inrush_block && !inrush && cycle_done;
	// Wide counter, so a stuck output cannot wrap past the bound
	always_ff @(posedge clk) begin
		on_r <= (resetn && cold_load) ? on_r + 32'h1 : 32'h0;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_reset_clears: assert property (disable iff (1'b0) !resetn |=> !cold_load && !inrush)
		else $error("outputs set after reset");
	a_rise_cause: assert property ($rose(cold_load) |-> $past(hi))
		else $error("cold load without start");
	a_block_at_rise: assert property ($rose(cold_load) |-> inrush_block)
		else $error("no blocking at rise");
	a_inrush_needs_cl: assert property (inrush || inrush_block |-> cold_load)
		else $error("inrush without cold load");
	a_zero_follow: assert property ($rose(cold_load) && harmonic_threshold == 8'h00 |-> inrush)
		else $error("inrush not following");
	a_pickup_drop: assert property (cold_load && lo |=> !cold_load && !inrush_block)
		else $error("no drop below pickup");
	a_harm_keep: assert property (first && hm |=> inrush && inrush_block)
		else $error("blocking not kept");
	a_harm_release: assert property (first && !hm |=> !inrush_block)
		else $error("blocking not released");
	a_max_hold: assert property (on_r <= (max_time + 32'h1) * (STEP_CYC + 1))
		else $error("cold load too long");
endmodule : cold_load_chk
bind cold_load_inrush_detector cold_load_chk #(.STEP_CYC(STEP_CYC)) i_cold_load_chk (.clk,
	.resetn, .phase_mag, .second_harmonic_ratio, .cycle_done, .start_threshold,
	.pickup_threshold, .max_time, .harmonic_threshold, .cold_load, .inrush, .inrush_block);

// file: testbench/phase_chain_model.sv
/* Measurement chain stand-in: cycle_done pulses once a cycle is analysed.
 Assumes start is held high from the current rise on. */
`timescale 1ns/1ps
module phase_chain_model (
	input wire logic clk,
	input wire logic start,
	output logic cycle_done
);
	logic [2:0] n_r;
	always_ff @(posedge clk) begin
		n_r <= start ? n_r + 3'h1 : 3'h0;
		cycle_done <= start && n_r == 3'h5;
	end
endmodule : phase_chain_model

// file: testbench/cold_load_inrush_detector_bench.sv
/* Self-checking bench for the detector.
 Assumes shortened window of 21 and step of 5 cycles (parameters 20 and 4). */
`timescale 1ns/1ps
module cold_load_inrush_detector_bench;
	typedef struct {logic [15:0] pk; int dly; logic [7:0] r; logic [7:0] t; logic [2:0] e;} row_t;
	logic clk = 0, resetn = 0, go = 0, cycle_done, cold_load, inrush, inrush_block;
	cold_load_pkg::phase_mag_t mag = '0;
	cold_load_pkg::phase_ratio_t rat = '0;
	logic [15:0] max_t = 16'h001E;
	logic [7:0] thr = 8'h00;
	int errors = 0, n_compared = 0, cyc = 0;
	row_t rows[5] = '{'{16'h00C8, 0, 8'h28, 8'h14, 3'h7}, '{16'h00C8, 0, 8'h0A, 8'h14, 3'h4},
		'{16'h00C8, 0, 8'h00, 8'h00, 3'h7}, '{16'h00C8, 25, 8'h28, 8'h14, 3'h0},
		'{16'h0050, 0, 8'h28, 8'h14, 3'h0}};
	cold_load_inrush_detector #(.RISE_WINDOW_CYC(20), .STEP_CYC(4)) i_cold_load_inrush_detector (
		.clk(clk), .resetn(resetn), .phase_mag(mag), .second_harmonic_ratio(rat),
		.cycle_done(cycle_done), .idle_current_threshold(16'h000A), .start_threshold(16'h0064),
		.pickup_threshold(16'h0032), .max_time(max_t), .harmonic_threshold(thr),
		.cold_load(cold_load), .inrush(inrush), .inrush_block(inrush_block));
	phase_chain_model i_phase_chain_model (.clk(clk), .start(go), .cycle_done(cycle_done));
	logic [2:0] outs;
	assign outs = {cold_load, inrush, inrush_block};
	task automatic check(input string nm, input logic [2:0] seen, input logic [2:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %b seen %b", nm, exp, seen);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	// Idle first, optional slow middle step, then the jump
	task automatic run(input logic [15:0] pk, input int dly);
		mag = '0;
		go = 0;
		repeat (4) @(negedge clk);
		if (dly > 0) begin
			mag.l2 = 16'h0050;
			repeat (dly) @(negedge clk);
		end
		mag.l2 = pk;
		go = 1;
		repeat (10) @(negedge clk);
	endtask : run
	initial forever #25 clk = ~clk;
	initial begin
		forever begin
			@(posedge clk);
			cyc++;
			if (cyc == 2000) begin
				errors++;
				tally_and_finish();
			end
		end
	end
	initial begin
		repeat (16) @(negedge clk);
		check("reset", outs, 3'h0);
		resetn = 1;
		foreach (rows[i]) begin
			rat.r3 = rows[i].r;
			thr = rows[i].t;
			run(rows[i].pk, rows[i].dly);
			check("row", outs, rows[i].e);
			mag.l2 = 16'h0031;
			go = 0;
			repeat (2) @(negedge clk);
			check("pickup", outs, 3'h0);
		end
		max_t = 16'h0003;
		run(16'h00C8, 0);
		check("max time on", outs, 3'h7);
		repeat (12) @(negedge clk);
		check("max time", outs, 3'h0);
		// Reset in mid-run while active
		max_t = 16'h001E;
		run(16'h00C8, 0);
		check("active", outs, 3'h7);
		resetn = 0;
		@(negedge clk);
		check("mid reset", outs, 3'h0);
		resetn = 1;
		repeat (2) @(negedge clk);
		check("after reset", outs, 3'h0);
		tally_and_finish();
	end
endmodule : cold_load_inrush_detector_bench
